// file: design/ubu_pkg.sv
// register map, field layout and encodings of the user break unit
// assumes a 32-bit apb slave port and a core that reports each bus cycle
package ubu_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_A_COND = 8'h04;
	localparam logic [7:0] OFS_A_ADDR = 8'h08;
	localparam logic [7:0] OFS_A_MASK = 8'h0c;
	localparam logic [7:0] OFS_A_ADDRESS_SPACE_IDENTIFIER = 8'h10;
	localparam logic [7:0] OFS_B_COND = 8'h14;
	localparam logic [7:0] OFS_B_ADDR = 8'h18;
	localparam logic [7:0] OFS_B_MASK = 8'h1c;
	localparam logic [7:0] OFS_B_ADDRESS_SPACE_IDENTIFIER = 8'h20;
	localparam logic [7:0] OFS_B_DATA = 8'h24;
	localparam logic [7:0] OFS_B_DMASK = 8'h28;
	// ----------------------------------------
	// break control fields
	// ----------------------------------------
	localparam int BIT_FLAG_A = 15;
	localparam int BIT_FLAG_B = 14;
	localparam int BIT_AFTER_A = 10;
	localparam int BIT_DATA_EN = 7;
	localparam int BIT_AFTER_B = 6;
	localparam int BIT_SEQ = 3;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'h04c8;
	// ----------------------------------------
	// cycle condition fields
	// ----------------------------------------
	localparam logic [1:0] TYPE_FETCH = 2'h1;
	localparam logic [1:0] TYPE_DATA = 2'h2;
	localparam logic [1:0] TYPE_ANY = 2'h3;
	localparam logic [1:0] DIR_READ = 2'h1;
	localparam logic [1:0] DIR_WRITE = 2'h2;
	localparam logic [1:0] DIR_ANY = 2'h3;
	localparam logic [1:0] SIZE_NONE = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_LONG = 2'h3;
	localparam logic [5:0] COND_RESET = 6'h00;
endpackage : ubu_pkg

// file: design/ubu_chan_if.sv
// settings and observed bus cycle shared by the top and one matcher
// assumes one instance per channel, all on the core clock
`timescale 1ns/10ps
interface ubu_chan_if;
	logic [5:0] cond;
	logic [31:0] addr;
	logic [31:0] mask;
	logic [7:0] address_space_identifier;
	logic [31:0] data;
	logic [31:0] dmask;
	logic dataEn;
	logic busValid;
	logic busFetch;
	logic busWrite;
	logic [1:0] busSize;
	logic [31:0] busAddr;
	logic [7:0] busAsid;
	logic [31:0] busData;
	logic hit;
	logic hitFetch;
	modport top (output cond, addr, mask, address_space_identifier, data, dmask, dataEn,
		busValid, busFetch, busWrite, busSize, busAddr, busAsid, busData,
		input hit, hitFetch);
	modport chan (input cond, addr, mask, address_space_identifier, data, dmask, dataEn,
		busValid, busFetch, busWrite, busSize, busAddr, busAsid, busData,
		output hit, hitFetch);
endinterface : ubu_chan_if

// file: design/ubu_chan_match.sv
// one break channel: compares a bus cycle against its programmed condition
// assumes the bus cycle fields are stable for the cycle busValid is high
`timescale 1ns/10ps
module ubu_chan_match (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// settings and observed cycle
	ubu_chan_if.chan ch
);
	function automatic logic [31:0] lowBits(input logic [1:0] size);
		unique case (size)
			ubu_pkg::SIZE_WORD: lowBits = 32'h00000001;
			ubu_pkg::SIZE_LONG: lowBits = 32'h00000003;
			default: lowBits = 32'h00000000;
		endcase
	endfunction : lowBits

	wire logic [1:0] cType = ch.cond[5:4];
	wire logic [1:0] cDir = ch.cond[3:2];
	wire logic [1:0] cSize = ch.cond[1:0];
	wire logic typeOk = (cType == ubu_pkg::TYPE_FETCH && ch.busFetch) ||
		(cType == ubu_pkg::TYPE_DATA && !ch.busFetch) ||
		(cType == ubu_pkg::TYPE_ANY);
	wire logic dirOk = (cDir == ubu_pkg::DIR_READ && !ch.busWrite) ||
		(cDir == ubu_pkg::DIR_WRITE && ch.busWrite) ||
		(cDir == ubu_pkg::DIR_ANY);
	wire logic sizeOk = (cSize == ubu_pkg::SIZE_NONE) ||
		(cSize == ch.busSize);
	// low address bits follow the real access size either way
	wire logic [31:0] ignore = ch.mask | lowBits(ch.busSize);
	wire logic addrOk = ((ch.busAddr ^ ch.addr) & ~ignore) == 32'h0;
	wire logic asidOk = ch.busAsid == ch.address_space_identifier;
	// fetches are even-addressed reads, so these settings never fire
	wire logic fetchBad = cType == ubu_pkg::TYPE_FETCH &&
		(cDir == ubu_pkg::DIR_WRITE || ch.addr[0]);
	wire logic [31:0] dWidth = (ch.busSize == ubu_pkg::SIZE_LONG) ?
		32'hffffffff : 32'h0000ffff;
	wire logic dataOk = !ch.dataEn || ch.busFetch ||
		((ch.busData ^ ch.data) & ~ch.dmask & dWidth) == 32'h0;
	wire logic hitD = ch.busValid && typeOk && dirOk && sizeOk &&
		addrOk && asidOk && dataOk && !fetchBad;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ch.hit <= 1'b0;
			ch.hitFetch <= 1'b0;
		end else begin
			ch.hit <= hitD;
			ch.hitFetch <= ch.busFetch;
		end
	end

	bad_fetch_a: assert property (@(posedge clk) disable iff (!resetn)
		(ch.busValid && fetchBad) |=> !ch.hit)
		else $error("fetch write or odd fetch address produced a hit");
	data_miss_a: assert property (@(posedge clk) disable iff (!resetn)
		(ch.dataEn && !ch.busFetch && !dataOk) |=> !ch.hit)
		else $error("data mismatch produced a hit");
endmodule : ubu_chan_match

// file: design/ubu_break_unit.sv
// user break unit top: apb registers, two matchers, break sequencing
// assumes the core reports one bus cycle per busValid pulse in the order
// the pipeline issues them, and pulses instrBoundary before each new
// instruction together with facts about the instruction boundary
`timescale 1ns/10ps
module ubu_break_unit (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// observed core bus cycle
	input wire logic busValid,
	input wire logic busFetch,
	input wire logic busWrite,
	input wire logic [1:0] busSize,
	input wire logic [31:0] busAddr,
	input wire logic [7:0] busAsid,
	input wire logic [31:0] busData,
	// instruction boundary facts
	input wire logic instrBoundary,
	input wire logic prevWasTrap,
	input wire logic nextRaisesExc,
	input wire logic nextIsSleep,
	input wire logic nextIsDelayBranch,
	input wire logic nmiDetected,
	// break requests and flags
	output logic breakBefore,
	output logic breakAfter,
	output logic matchFlagA,
	output logic matchFlagB
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [15:0] ctrl_q;
	logic [5:0] condA_q, condB_q;
	logic [31:0] addrA_q, addrB_q, maskA_q, maskB_q;
	logic [7:0] asidA_q, asidB_q;
	logic [31:0] dataB_q, dmaskB_q;
	logic [31:0] prdata_q;
	logic flagA_q, flagB_q, armed_q;
	logic pend_q, pendFetch_q, pendCmp_q;
	logic before_q, after_q;
	logic [31:0] readMux;

	ubu_chan_if chA ();
	ubu_chan_if chB ();

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire logic setup = psel && !penable;
	wire logic wrEn = psel && penable && pwrite;
	wire logic isCtrl = paddr == ubu_pkg::OFS_CTRL;
	wire logic mapped = isCtrl || paddr == ubu_pkg::OFS_A_COND ||
		paddr == ubu_pkg::OFS_A_ADDR || paddr == ubu_pkg::OFS_A_MASK ||
		paddr == ubu_pkg::OFS_A_ADDRESS_SPACE_IDENTIFIER || paddr == ubu_pkg::OFS_B_COND ||
		paddr == ubu_pkg::OFS_B_ADDR || paddr == ubu_pkg::OFS_B_MASK ||
		paddr == ubu_pkg::OFS_B_ADDRESS_SPACE_IDENTIFIER || paddr == ubu_pkg::OFS_B_DATA ||
		paddr == ubu_pkg::OFS_B_DMASK;
	wire logic wrCtrl = wrEn && isCtrl;
	// writing zero to a flag bit clears it
	wire logic clrA = wrCtrl && !pwdata[ubu_pkg::BIT_FLAG_A];
	wire logic clrB = wrCtrl && !pwdata[ubu_pkg::BIT_FLAG_B];
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_q;
	// flags live outside ctrl_q, so they are merged back in for reads
	wire logic [31:0] ctrlRead = {16'h0, flagA_q, flagB_q,
		ctrl_q[13:0]};

	always_comb begin
		unique case (paddr)
			ubu_pkg::OFS_CTRL: readMux = ctrlRead;
			ubu_pkg::OFS_A_COND: readMux = {26'h0, condA_q};
			ubu_pkg::OFS_A_ADDR: readMux = addrA_q;
			ubu_pkg::OFS_A_MASK: readMux = maskA_q;
			ubu_pkg::OFS_A_ADDRESS_SPACE_IDENTIFIER: readMux = {24'h0, asidA_q};
			ubu_pkg::OFS_B_COND: readMux = {26'h0, condB_q};
			ubu_pkg::OFS_B_ADDR: readMux = addrB_q;
			ubu_pkg::OFS_B_MASK: readMux = maskB_q;
			ubu_pkg::OFS_B_ADDRESS_SPACE_IDENTIFIER: readMux = {24'h0, asidB_q};
			ubu_pkg::OFS_B_DATA: readMux = dataB_q;
			ubu_pkg::OFS_B_DMASK: readMux = dmaskB_q;
			default: readMux = 32'h0;
		endcase
	end

	// read data is caught in the setup cycle so the access needs no wait
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata_q <= 32'h0;
		end else if (setup && !pwrite) begin
			prdata_q <= readMux;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= ubu_pkg::CTRL_RESET;
			condA_q <= ubu_pkg::COND_RESET;
			condB_q <= ubu_pkg::COND_RESET;
			addrA_q <= 32'h0;
			addrB_q <= 32'h0;
			maskA_q <= 32'h0;
			maskB_q <= 32'h0;
			asidA_q <= 8'h0;
			asidB_q <= 8'h0;
			dataB_q <= 32'h0;
			dmaskB_q <= 32'h0;
		end else if (wrEn) begin
			unique case (paddr)
				ubu_pkg::OFS_CTRL: ctrl_q <= pwdata[15:0] & ubu_pkg::CTRL_WMASK;
				ubu_pkg::OFS_A_COND: condA_q <= pwdata[5:0];
				ubu_pkg::OFS_A_ADDR: addrA_q <= pwdata;
				ubu_pkg::OFS_A_MASK: maskA_q <= pwdata;
				ubu_pkg::OFS_A_ADDRESS_SPACE_IDENTIFIER: asidA_q <= pwdata[7:0];
				ubu_pkg::OFS_B_COND: condB_q <= pwdata[5:0];
				ubu_pkg::OFS_B_ADDR: addrB_q <= pwdata;
				ubu_pkg::OFS_B_MASK: maskB_q <= pwdata;
				ubu_pkg::OFS_B_ADDRESS_SPACE_IDENTIFIER: asidB_q <= pwdata[7:0];
				ubu_pkg::OFS_B_DATA: dataB_q <= pwdata;
				ubu_pkg::OFS_B_DMASK: dmaskB_q <= pwdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// channel matchers
	// ----------------------------------------
	wire logic seqMode = ctrl_q[ubu_pkg::BIT_SEQ];
	wire logic dataEn = ctrl_q[ubu_pkg::BIT_DATA_EN];
	wire logic afterA = ctrl_q[ubu_pkg::BIT_AFTER_A];
	wire logic afterB = ctrl_q[ubu_pkg::BIT_AFTER_B];

	assign chA.cond = condA_q;
	assign chA.addr = addrA_q;
	assign chA.mask = maskA_q;
	assign chA.address_space_identifier = asidA_q;
	assign chA.data = 32'h0;
	assign chA.dmask = 32'hffffffff;
	assign chA.dataEn = 1'b0;
	assign chB.cond = condB_q;
	assign chB.addr = addrB_q;
	assign chB.mask = maskB_q;
	assign chB.address_space_identifier = asidB_q;
	assign chB.data = dataB_q;
	assign chB.dmask = dmaskB_q;
	assign chB.dataEn = dataEn;
	assign chA.busValid = busValid;
	assign chA.busFetch = busFetch;
	assign chA.busWrite = busWrite;
	assign chA.busSize = busSize;
	assign chA.busAddr = busAddr;
	assign chA.busAsid = busAsid;
	assign chA.busData = busData;
	assign chB.busValid = busValid;
	assign chB.busFetch = busFetch;
	assign chB.busWrite = busWrite;
	assign chB.busSize = busSize;
	assign chB.busAddr = busAddr;
	assign chB.busAsid = busAsid;
	assign chB.busData = busData;

	ubu_chan_match uChanA (
		.clk(clk),
		.resetn(resetn),
		.ch(chA.chan)
	);

	ubu_chan_match uChanB (
		.clk(clk),
		.resetn(resetn),
		.ch(chB.chan)
	);

	// ----------------------------------------
	// break sequencing
	// ----------------------------------------
	wire logic hitA = chA.hit;
	wire logic hitB = chB.hit;
	// armed is registered, so a b hit in a's own cycle cannot complete
	wire logic evA = hitA && !seqMode;
	wire logic evB = hitB && (!seqMode || armed_q);
	wire logic fetchA = chA.hitFetch;
	wire logic fetchB = chB.hitFetch;
	wire logic beforeEv = (evA && fetchA && !afterA) ||
		(evB && fetchB && (!afterB || seqMode));
	wire logic afterEv = (evA && !(fetchA && !afterA)) ||
		(evB && !(fetchB && (!afterB || seqMode)));
	wire logic afterFetchEv = (evA && fetchA && afterA) ||
		(evB && fetchB && afterB && !seqMode);
	wire logic cmpEv = evB && !fetchB && dataEn;
	// a trap after the matched fetch or an nmi takes precedence
	wire logic supFetch = pendFetch_q && (prevWasTrap || nmiDetected);
	// sleep always wins; an exception wins unless the next is a delayed branch
	wire logic supCmp = pendCmp_q &&
		((nextRaisesExc && !nextIsDelayBranch) || nextIsSleep);
	wire logic fireAfter = instrBoundary && pend_q && !supFetch &&
		!supCmp;
	// a new b hit in sequential mode consumes the arming
	wire logic armedD = !seqMode ? 1'b0 :
		(hitB && armed_q) ? hitA :
		(hitA ? 1'b1 : armed_q);

	// ----------------------------------------
	// arming and match flags
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			armed_q <= 1'b0;
			flagA_q <= 1'b0;
			flagB_q <= 1'b0;
		end else begin
			armed_q <= armedD;
			flagA_q <= hitA || (flagA_q && !clrA);
			flagB_q <= evB || (flagB_q && !clrB);
		end
	end

	// a before break on the same cycle drops any after break
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pend_q <= 1'b0;
			pendFetch_q <= 1'b0;
			pendCmp_q <= 1'b0;
		end else if (beforeEv) begin
			pend_q <= 1'b0;
			pendFetch_q <= 1'b0;
			pendCmp_q <= 1'b0;
		end else if (afterEv) begin
			pend_q <= 1'b1;
			pendFetch_q <= afterFetchEv;
			pendCmp_q <= cmpEv;
		end else if (instrBoundary) begin
			pend_q <= 1'b0;
			pendFetch_q <= 1'b0;
			pendCmp_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			before_q <= 1'b0;
			after_q <= 1'b0;
		end else begin
			before_q <= beforeEv;
			after_q <= fireAfter && !beforeEv;
		end
	end

	assign breakBefore = before_q;
	assign breakAfter = after_q;
	assign matchFlagA = flagA_q;
	assign matchFlagB = flagB_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	seq_same_cycle_a: assert property (@(posedge clk) disable iff (!resetn)
		(seqMode && hitA && hitB && !armed_q) |=> !breakBefore && !pend_q)
		else $error("sequential break completed in channel a cycle");
	seq_before_a: assert property (@(posedge clk) disable iff (!resetn)
		(ctrl_q == 16'h0008 && armed_q && hitB && fetchB) |=> breakBefore)
		else $error("sequential fetch match did not break before");
	data_mode_a: assert property (@(posedge clk) disable iff (!resetn)
		(ctrl_q == 16'h0080 && hitB && !fetchB && !beforeEv) |=>
		(pend_q && pendCmp_q))
		else $error("data-break setting not applied");
	seq_arm_a: assert property (@(posedge clk) disable iff (!resetn)
		(seqMode && hitA) |=> armed_q)
		else $error("channel a hit did not arm the sequence");
	seq_no_after_a: assert property (@(posedge clk) disable iff (!resetn)
		(seqMode && evB && fetchB) |=> !pend_q)
		else $error("sequential fetch break left an after break pending");
	both_before_a: assert property (@(posedge clk) disable iff (!resetn)
		(beforeEv && afterEv) |=> breakBefore && !pend_q ##1 !breakAfter)
		else $error("before break did not win over after break");
	trap_skip_a: assert property (@(posedge clk) disable iff (!resetn)
		(instrBoundary && pend_q && pendFetch_q && prevWasTrap && !beforeEv)
		|=> !breakAfter)
		else $error("after break taken on trap instruction");
	exc_skip_a: assert property (@(posedge clk) disable iff (!resetn)
		(instrBoundary && pendCmp_q && nextRaisesExc && !nextIsDelayBranch)
		|=> !breakAfter)
		else $error("data break taken before exception");
	sleep_skip_a: assert property (@(posedge clk) disable iff (!resetn)
		(instrBoundary && pendCmp_q && nextIsSleep) |=> !breakAfter)
		else $error("data break taken before sleep");
	nmi_skip_a: assert property (@(posedge clk) disable iff (!resetn)
		(instrBoundary && pendFetch_q && nmiDetected) |=> !breakAfter)
		else $error("fetch after break taken over nmi");
	flag_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		(matchFlagA && !clrA) |=> matchFlagA)
		else $error("flag a dropped without a clear");
	flag_b_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		(matchFlagB && !clrB) |=> matchFlagB)
		else $error("flag b dropped without a clear");
	flag_set_a: assert property (@(posedge clk) disable iff (!resetn)
		(hitA && evB) |=> (matchFlagA && matchFlagB))
		else $error("match flags not both set");
	after_bound_a: assert property (@(posedge clk) disable iff (!resetn)
		breakAfter |-> $past(instrBoundary))
		else $error("after break raised away from an instruction boundary");
	cov_both_c: cover property (@(posedge clk) disable iff (!resetn)
		beforeEv && afterEv);
	cov_data_c: cover property (@(posedge clk) disable iff (!resetn)
		cmpEv ##[1:10] breakAfter);
	cov_seq_c: cover property (@(posedge clk) disable iff (!resetn)
		seqMode && hitA ##[1:20] evB);
	cov_after_c: cover property (@(posedge clk) disable iff (!resetn)
		afterEv ##[1:10] breakAfter);
	cov_skip_c: cover property (@(posedge clk) disable iff (!resetn)
		instrBoundary && pend_q && (supFetch || supCmp));
endmodule : ubu_break_unit

// file: verif/ubu_core_model.sv
// core-side model: issues bus cycles and instruction boundaries
// assumes its tasks are called just after a rising clock edge
`timescale 1ns/10ps
module ubu_core_model (
	// clock
	input wire logic clk,
	// bus cycle
	output logic busValid,
	output logic busFetch,
	output logic busWrite,
	output logic [1:0] busSize,
	output logic [31:0] busAddr,
	output logic [7:0] busAsid,
	output logic [31:0] busData,
	// boundary facts
	output logic instrBoundary,
	output logic prevWasTrap,
	output logic nextRaisesExc,
	output logic nextIsSleep,
	output logic nextIsDelayBranch,
	output logic nmiDetected
);
	// ----------------------------------------
	// drivers
	// ----------------------------------------
	initial begin
		{busValid, busFetch, busWrite, busSize, busAsid} = '0;
		{busAddr, busData} = '0;
		{instrBoundary, prevWasTrap, nextRaisesExc, nextIsSleep} = '0;
		nextIsDelayBranch = 1'b0;
		nmiDetected = 1'b0;
	end
	// one cycle per call, in issue order
	task cyc(input logic f, input logic w, input logic [1:0] s,
		input logic [31:0] a, input logic [7:0] id,
		input logic [31:0] d);
		busValid <= 1'b1;
		busFetch <= f;
		busWrite <= w;
		busSize <= s;
		busAddr <= a;
		busAsid <= id;
		busData <= d;
		@(posedge clk);
		busValid <= 1'b0;
		// fields mean nothing after the cycle, so invert the address, asid and data
		busAddr <= ~a;
		busAsid <= ~id;
		busData <= ~d;
		@(posedge clk);
	endtask : cyc
	task bound(input logic t, input logic e, input logic sl, input logic n);
		instrBoundary <= 1'b1;
		prevWasTrap <= t;
		nextRaisesExc <= e;
		nextIsSleep <= sl;
		nmiDetected <= n;
		@(posedge clk);
		{instrBoundary, prevWasTrap, nextRaisesExc} <= 3'h0;
		{nextIsSleep, nmiDetected} <= 2'h0;
		@(posedge clk);
	endtask : bound
	// next instruction is a delayed branch that also raises an exception
	task branchExc();
		instrBoundary <= 1'b1;
		nextRaisesExc <= 1'b1;
		nextIsDelayBranch <= 1'b1;
		@(posedge clk);
		{instrBoundary, nextRaisesExc, nextIsDelayBranch} <= 3'h0;
		@(posedge clk);
	endtask : branchExc
endmodule : ubu_core_model

// file: verif/test_user_break_condition_unit.sv
// bench for the break unit: apb master, core model, break scoreboard
// assumes zero-wait apb and a single 50 MHz core clock
`timescale 1ns/10ps
module test_user_break_condition_unit;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, perr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, a, dv;
	logic breakBefore, breakAfter, matchFlagA, matchFlagB;
	logic busValid, busFetch, busWrite, instrBoundary, prevWasTrap;
	logic nextRaisesExc, nextIsSleep, nextIsDelayBranch, nmiDetected;
	logic [1:0] busSize;
	logic [31:0] busAddr, busData;
	logic [7:0] busAsid;
	logic [1:0] expQ[$];
	logic [1:0] szTab[3] = '{2'h3, 2'h2, 2'h1};
	logic [31:0] adTab[3] = '{32'h00123454, 32'h00123456, 32'h00123456};
	int failCount = 0;
	int cmpCount = 0;
	ubu_break_unit dut (.clk(clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.busValid(busValid), .busFetch(busFetch), .busWrite(busWrite),
		.busSize(busSize), .busAddr(busAddr), .busAsid(busAsid),
		.busData(busData), .instrBoundary(instrBoundary),
		.prevWasTrap(prevWasTrap), .nextRaisesExc(nextRaisesExc),
		.nextIsSleep(nextIsSleep), .nextIsDelayBranch(nextIsDelayBranch),
		.nmiDetected(nmiDetected), .breakBefore(breakBefore),
		.breakAfter(breakAfter), .matchFlagA(matchFlagA),
		.matchFlagB(matchFlagB));
	ubu_core_model core (.clk(clk), .busValid(busValid),
		.busFetch(busFetch), .busWrite(busWrite), .busSize(busSize),
		.busAddr(busAddr), .busAsid(busAsid), .busData(busData),
		.instrBoundary(instrBoundary), .prevWasTrap(prevWasTrap),
		.nextRaisesExc(nextRaisesExc), .nextIsSleep(nextIsSleep),
		.nextIsDelayBranch(nextIsDelayBranch), .nmiDetected(nmiDetected));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			failCount++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task wr(input logic [7:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d);
	endtask : wr
	task rdc(input logic [7:0] ad, input logic [31:0] exp);
		apb(1'b0, ad, 32'h0);
		chk(rd, exp);
	endtask : rdc
	// a missing break shows as a note left on the queue
	task settle(input string name);
		repeat (6) @(posedge clk);
		chk(32'(expQ.size()), 32'h0);
		$display("test %s done", name);
	endtask : settle
	task endSim();
		$display("comparisons %0d mismatches %0d", cmpCount, failCount);
		if (failCount == 0 && cmpCount > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : endSim
	// ----------------------------------------
	// break scoreboard and clocking
	// ----------------------------------------
	always @(posedge clk) begin
		if (breakBefore === 1'b1 || breakAfter === 1'b1) begin
			if (expQ.size() == 0) chk({30'h0, breakBefore, breakAfter}, 32'h0);
			else chk({30'h0, breakBefore, breakAfter}, {30'h0, expQ.pop_front()});
		end
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		failCount++;
		endSim();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata} = '0;
		void'($urandom(48926));
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rdc(ubu_pkg::OFS_CTRL, 32'h0);
		rdc(8'h2c, 32'h0);
		chk({31'h0, perr}, 32'h1);
		$display("test reset done");
		wr(ubu_pkg::OFS_CTRL, 32'h0008);
		wr(ubu_pkg::OFS_A_COND, 32'h16);
		wr(ubu_pkg::OFS_A_ADDR, 32'h00037226);
		wr(ubu_pkg::OFS_A_ADDRESS_SPACE_IDENTIFIER, 32'h80);
		wr(ubu_pkg::OFS_B_COND, 32'h16);
		wr(ubu_pkg::OFS_B_ADDR, 32'h0003722e);
		wr(ubu_pkg::OFS_B_ADDRESS_SPACE_IDENTIFIER, 32'h70);
		core.cyc(1'b1, 1'b0, 2'h2, 32'h0003722e, 8'h70, 32'h0);
		core.cyc(1'b1, 1'b0, 2'h2, 32'h00037226, 8'h80, 32'h0);
		expQ.push_back(2'b10);
		core.cyc(1'b1, 1'b0, 2'h2, 32'h0003722e, 8'h70, 32'h0);
		settle("sequential");
		chk({30'h0, matchFlagA, matchFlagB}, 32'h3);
		rdc(ubu_pkg::OFS_CTRL, 32'hc008);
		wr(ubu_pkg::OFS_CTRL, 32'h0080);
		rdc(ubu_pkg::OFS_CTRL, 32'h0080);
		wr(ubu_pkg::OFS_A_COND, 32'h24);
		wr(ubu_pkg::OFS_A_ADDR, 32'h00123456);
		wr(ubu_pkg::OFS_B_COND, 32'h2a);
		wr(ubu_pkg::OFS_B_ADDR, 32'h000abcde);
		wr(ubu_pkg::OFS_B_MASK, 32'h00000ffe);
		wr(ubu_pkg::OFS_B_DATA, 32'h0000a512);
		for (int i = 0; i < 3; i++) begin
			expQ.push_back(2'b01);
			core.cyc(1'b0, 1'b0, szTab[i], adTab[i], 8'h80, $urandom);
			core.bound(1'b0, 1'b0, 1'b0, 1'b0);
		end
		a = 32'h000ab000 | ($urandom & 32'h00000ffe);
		dv = $urandom;
		expQ.push_back(2'b01);
		core.cyc(1'b0, 1'b1, 2'h2, a, 8'h70, {dv[31:16], 16'ha512});
		core.bound(1'b0, 1'b0, 1'b0, 1'b0);
		core.cyc(1'b0, 1'b1, 2'h2, a, 8'h70, 32'h0000a513);
		core.bound(1'b0, 1'b0, 1'b0, 1'b0);
		core.cyc(1'b0, 1'b1, 2'h2, a, 8'h71, 32'h0000a512);
		core.bound(1'b0, 1'b0, 1'b0, 1'b0);
		settle("data break");
		rdc(ubu_pkg::OFS_CTRL, 32'hc080);
		wr(ubu_pkg::OFS_CTRL, 32'h0080);
		wr(ubu_pkg::OFS_A_COND, 32'h0);
		core.cyc(1'b0, 1'b1, 2'h2, a, 8'h70, 32'h0000a512);
		core.bound(1'b0, 1'b1, 1'b0, 1'b0);
		core.cyc(1'b0, 1'b1, 2'h2, a, 8'h70, 32'h0000a512);
		core.bound(1'b0, 1'b0, 1'b1, 1'b0);
		expQ.push_back(2'b01);
		core.cyc(1'b0, 1'b1, 2'h2, a, 8'h70, 32'h0000a512);
		core.branchExc();
		settle("data suppress");
		rdc(ubu_pkg::OFS_CTRL, 32'h4080);
		chk({30'h0, matchFlagA, matchFlagB}, 32'h1);
		wr(ubu_pkg::OFS_CTRL, 32'h0400);
		wr(ubu_pkg::OFS_B_COND, 32'h0);
		wr(ubu_pkg::OFS_A_COND, 32'h14);
		wr(ubu_pkg::OFS_A_ADDR, 32'h00001000);
		wr(ubu_pkg::OFS_A_ADDRESS_SPACE_IDENTIFIER, 32'h05);
		core.cyc(1'b1, 1'b0, 2'h2, 32'h00001000, 8'h05, 32'h0);
		core.bound(1'b1, 1'b0, 1'b0, 1'b0);
		core.cyc(1'b1, 1'b0, 2'h2, 32'h00001000, 8'h05, 32'h0);
		core.bound(1'b0, 1'b0, 1'b0, 1'b1);
		settle("fetch suppress");
		rdc(ubu_pkg::OFS_CTRL, 32'h8400);
		expQ.push_back(2'b01);
		core.cyc(1'b1, 1'b0, 2'h2, 32'h00001000, 8'h05, 32'h0);
		core.bound(1'b0, 1'b0, 1'b0, 1'b0);
		settle("fetch after");
		wr(ubu_pkg::OFS_CTRL, 32'h0400);
		wr(ubu_pkg::OFS_B_COND, 32'h14);
		wr(ubu_pkg::OFS_B_ADDR, 32'h00001000);
		wr(ubu_pkg::OFS_B_MASK, 32'h0);
		wr(ubu_pkg::OFS_B_ADDRESS_SPACE_IDENTIFIER, 32'h05);
		expQ.push_back(2'b10);
		core.cyc(1'b1, 1'b0, 2'h2, 32'h00001000, 8'h05, 32'h0);
		core.bound(1'b0, 1'b0, 1'b0, 1'b0);
		settle("before and after");
		rdc(ubu_pkg::OFS_CTRL, 32'hc400);
		wr(ubu_pkg::OFS_CTRL, 32'h0000);
		wr(ubu_pkg::OFS_A_COND, 32'h1a);
		wr(ubu_pkg::OFS_A_ADDR, 32'h00027128);
		wr(ubu_pkg::OFS_B_ADDR, 32'h00031415);
		core.cyc(1'b1, 1'b1, 2'h2, 32'h00027128, 8'h05, 32'h0);
		core.cyc(1'b1, 1'b0, 2'h2, 32'h00031414, 8'h05, 32'h0);
		rdc(ubu_pkg::OFS_CTRL, 32'h0);
		settle("bad settings");
		endSim();
	end
endmodule : test_user_break_condition_unit
